// >>> logic/trt_defs.vh
`ifndef TRT_DEFS_VH
`define TRT_DEFS_VH

// register offsets (7-bit register address)
`define TRT_ADDR_CNT_LO 7'h18
`define TRT_ADDR_CNT_HI 7'h19
`define TRT_ADDR_TEMP 7'h20
`define TRT_ADDR_USER0 7'h28
`define TRT_ADDR_USER1 7'h29
`define TRT_ADDR_CTRL 7'h30
`define TRT_ADDR_XOFS 7'h31
`define TRT_ADDR_XCOEF 7'h32
`define TRT_ADDR_XT0 7'h33

// control register fields
`define TRT_CTRL_RES_LARGEST 7
`define TRT_CTRL_RES_LARGE 6
`define TRT_CTRL_RES_MEDIUM 5
`define TRT_CTRL_RES_SMALL 4
`define TRT_CTRL_SEL_HI 3
`define TRT_CTRL_SEL_LO 2
`define TRT_CTRL_THERM_EN 1
`define TRT_CTRL_SCAN_SEL 0

// crystal offset fields
`define TRT_XOFS_SIGN 7
`define TRT_XOFS_MAG_MAX 7'h79
`define TRT_XT0_MASK 8'h3f

// command byte fields
`define TRT_CMD_READ 7

// reset values
`define TRT_CNT_LO_RST 8'h01
`define TRT_CNT_HI_RST 8'h00
`define TRT_TEMP_RST 8'h3c
`define TRT_USER_RST 8'h00
`define TRT_CTRL_RST 8'h02
`define TRT_XOFS_RST 8'h00
`define TRT_XCOEF_RST 8'h00
`define TRT_XT0_RST 8'h00

// timing
`define TRT_CLK_HZ 200000000
`define TRT_SCAN_FAST_S 1
`define TRT_SCAN_SLOW_S 16
`define TRT_SEC_CYCLES (`TRT_CLK_HZ * `TRT_SCAN_FAST_S)

`endif

// >>> logic/trt_regs.v
`timescale 1ns/10ps
`include "trt_defs.vh"

module trt_regs #(
  parameter SEC_CYCLES = `TRT_SEC_CYCLES
) (
  input wire clk,
  input wire rst_n,
  input wire spi_sclk,
  input wire spi_cs_n,
  input wire spi_mosi,
  output reg spi_miso_o,
  output reg spi_miso_oe,
  input wire [7:0] temp_meas_value,
  input wire temp_meas_done,
  output reg temp_meas_req,
  output wire [15:0] countdown_value,
  output wire charge_res_largest_en,
  output wire charge_res_large_en,
  output wire charge_res_medium_en,
  output wire charge_res_small_en,
  output wire clk_out_sel_hi,
  output wire clk_out_sel_lo,
  output wire therm_en,
  output wire temp_scan_interval_sel,
  output wire [7:0] temp_value,
  output wire crystal_frequency_offset_fast,
  output wire [6:0] crystal_frequency_offset_mag,
  output wire [7:0] xtal_coef,
  output wire [5:0] xtal_turnover
);

  // register storage
  reg [7:0] cnt_lo;
  reg [7:0] cnt_hi;
  reg [7:0] temp_live;
  reg [7:0] temp_cache;
  reg [7:0] user0;
  reg [7:0] user1;
  reg [7:0] ctrl;
  reg [7:0] xofs;
  reg [7:0] xcoef;
  reg [7:0] xt0;

  // pin synchronisers
  reg cs_m;
  reg cs_s;
  reg sclk_m;
  reg sclk_s;
  reg sclk_d;
  reg mosi_m;
  reg mosi_s;

  // serial engine
  reg [2:0] bit_cnt;
  reg have_cmd;
  reg is_read;
  reg [6:0] addr;
  reg [7:0] sh_in;
  reg [7:0] sh_out;
  reg wr_stb;
  reg [6:0] wr_addr;
  reg [7:0] wr_data;

  // scan timing
  reg [27:0] sec_cnt;
  reg [3:0] scan_cnt;

  wire active;
  wire sclk_rise;
  wire sclk_fall;
  wire [7:0] next_byte;
  wire [6:0] next_addr;
  wire sec_tick;

  assign active = ~cs_s;
  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;
  assign next_byte = {sh_in[6:0], mosi_s};
  assign next_addr = addr + 7'h01;
  assign sec_tick = (sec_cnt == SEC_CYCLES - 1);

  assign countdown_value = {cnt_hi, cnt_lo};
  assign charge_res_largest_en = ctrl[`TRT_CTRL_RES_LARGEST];
  assign charge_res_large_en = ctrl[`TRT_CTRL_RES_LARGE];
  assign charge_res_medium_en = ctrl[`TRT_CTRL_RES_MEDIUM];
  assign charge_res_small_en = ctrl[`TRT_CTRL_RES_SMALL];
  assign clk_out_sel_hi = ctrl[`TRT_CTRL_SEL_HI];
  assign clk_out_sel_lo = ctrl[`TRT_CTRL_SEL_LO];
  assign therm_en = ctrl[`TRT_CTRL_THERM_EN];
  assign temp_scan_interval_sel = ctrl[`TRT_CTRL_SCAN_SEL];
  assign temp_value = temp_live;
  assign crystal_frequency_offset_fast = xofs[`TRT_XOFS_SIGN];
  assign crystal_frequency_offset_mag = xofs[6:0];
  assign xtal_coef = xcoef;
  assign xtal_turnover = xt0[5:0];

  // read decode, used at command end and at each following byte
  function [7:0] rd_data;
    input [6:0] a;
    begin
      case (a)
        `TRT_ADDR_CNT_LO: rd_data = cnt_lo;
        `TRT_ADDR_CNT_HI: rd_data = cnt_hi;
        `TRT_ADDR_TEMP: rd_data = temp_cache;
        `TRT_ADDR_USER0: rd_data = user0;
        `TRT_ADDR_USER1: rd_data = user1;
        `TRT_ADDR_CTRL: rd_data = ctrl;
        `TRT_ADDR_XOFS: rd_data = xofs;
        `TRT_ADDR_XCOEF: rd_data = xcoef;
        `TRT_ADDR_XT0: rd_data = xt0;
        default: rd_data = 8'h00;
      endcase
    end
  endfunction

  // pins are asynchronous to clk; edges are found on the second stage only
  always @(posedge clk) begin
    if (!rst_n) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      sclk_m <= 1'b0;
      sclk_s <= 1'b0;
      sclk_d <= 1'b0;
      mosi_m <= 1'b0;
      mosi_s <= 1'b0;
    end else begin
      cs_m <= spi_cs_n;
      cs_s <= cs_m;
      sclk_m <= spi_sclk;
      sclk_s <= sclk_m;
      sclk_d <= sclk_s;
      mosi_m <= spi_mosi;
      mosi_s <= mosi_m;
    end
  end

  // serial slave: command byte (read flag, address), then data bytes with auto-increment
  always @(posedge clk) begin
    if (!rst_n) begin
      bit_cnt <= 3'h0;
      have_cmd <= 1'b0;
      is_read <= 1'b0;
      addr <= 7'h00;
      sh_in <= 8'h00;
      sh_out <= 8'h00;
      wr_stb <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
      spi_miso_o <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      if (!active) begin
        bit_cnt <= 3'h0;
        have_cmd <= 1'b0;
        is_read <= 1'b0;
        spi_miso_oe <= 1'b0;
      end else begin
        spi_miso_oe <= have_cmd & is_read;
        if (sclk_rise) begin
          sh_in <= next_byte;
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            if (!have_cmd) begin
              have_cmd <= 1'b1;
              is_read <= next_byte[`TRT_CMD_READ];
              addr <= next_byte[6:0];
              sh_out <= rd_data(next_byte[6:0]);
            end else begin
              if (!is_read) begin
                wr_stb <= 1'b1;
                wr_addr <= addr;
                wr_data <= next_byte;
              end
              addr <= next_addr;
              sh_out <= rd_data(next_addr);
            end
          end
        end else if (sclk_fall) begin
          spi_miso_o <= sh_out[7];
          sh_out <= {sh_out[6:0], 1'b0};
        end
      end
    end
  end

  // one-second base tick; the long interval counts sixteen of them
  // limit: SEC_CYCLES must fit the 28-bit counter
  always @(posedge clk) begin
    if (!rst_n) begin
      sec_cnt <= 28'h0000000;
      scan_cnt <= 4'h0;
      temp_meas_req <= 1'b0;
    end else begin
      temp_meas_req <= 1'b0;
      if (sec_tick) begin
        sec_cnt <= 28'h0000000;
        scan_cnt <= scan_cnt + 4'h1;
        if (therm_en) begin
          if (temp_scan_interval_sel) begin
            temp_meas_req <= (scan_cnt == 4'hf);
          end else begin
            temp_meas_req <= 1'b1;
          end
        end
      end else begin
        sec_cnt <= sec_cnt + 28'h0000001;
      end
    end
  end

  // register file
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_lo <= `TRT_CNT_LO_RST;
      cnt_hi <= `TRT_CNT_HI_RST;
      temp_live <= `TRT_TEMP_RST;
      temp_cache <= `TRT_TEMP_RST;
      user0 <= `TRT_USER_RST;
      user1 <= `TRT_USER_RST;
      ctrl <= `TRT_CTRL_RST;
      xofs <= `TRT_XOFS_RST;
      xcoef <= `TRT_XCOEF_RST;
      xt0 <= `TRT_XT0_RST;
    end else begin
      if (therm_en && temp_meas_done) begin
        temp_live <= temp_meas_value;
      end
      // with the thermometer off, the host's own temperature write below still refreshes the cache
      // cache follows only while idle
      if (!active) begin
        temp_cache <= (therm_en && temp_meas_done) ? temp_meas_value : temp_live;
      end
      if (wr_stb) begin
        case (wr_addr)
          `TRT_ADDR_CNT_LO: begin
            if (wr_data != 8'h00) begin
              cnt_lo <= wr_data;
            end
          end
          `TRT_ADDR_CNT_HI: cnt_hi <= wr_data;
          `TRT_ADDR_TEMP: begin
            if (!therm_en) begin
              temp_live <= wr_data;
              temp_cache <= wr_data;
            end
          end
          `TRT_ADDR_USER0: user0 <= wr_data;
          `TRT_ADDR_USER1: user1 <= wr_data;
          `TRT_ADDR_CTRL: ctrl <= wr_data;
          `TRT_ADDR_XOFS: begin
            // out-of-range magnitudes would overdrive the compensation
            // magnitude clamped to 121
            if (wr_data[6:0] > `TRT_XOFS_MAG_MAX) begin
              xofs <= {wr_data[`TRT_XOFS_SIGN], `TRT_XOFS_MAG_MAX};
            end else begin
              xofs <= wr_data;
            end
          end
          `TRT_ADDR_XCOEF: xcoef <= wr_data;
          `TRT_ADDR_XT0: xt0 <= wr_data & `TRT_XT0_MASK;
          default: begin
          end
        endcase
      end
    end
  end

endmodule // trt_regs

// >>> test/trt_regs_sva.sv
`timescale 1ns/10ps
module trt_regs_sva #(
  parameter SEC_CYCLES = 20
) (
  input wire clk,
  input wire rst_n,
  input wire spi_cs_n,
  input wire [7:0] temp_meas_value,
  input wire temp_meas_done,
  input wire temp_meas_req,
  input wire [15:0] countdown_value,
  input wire clk_out_sel_hi,
  input wire clk_out_sel_lo,
  input wire therm_en,
  input wire temp_scan_interval_sel,
  input wire [7:0] temp_value,
  input wire [6:0] crystal_frequency_offset_mag
);
  localparam int FAST = SEC_CYCLES;
  localparam int SLOW = 16 * SEC_CYCLES;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_lo; countdown_value[7:0] != 8'h00; endproperty
  a_lo: assert property (p_lo) else $error("timer low byte zero");
  property p_cnt; $changed(countdown_value) |-> !spi_cs_n; endproperty
  a_cnt: assert property (p_cnt) else $error("timer moved while idle");
  property p_ctl; $changed({clk_out_sel_hi, clk_out_sel_lo, therm_en, temp_scan_interval_sel}) |-> !spi_cs_n; endproperty
  a_ctl: assert property (p_ctl) else $error("control moved while idle");
  property p_mag; crystal_frequency_offset_mag <= 7'h79; endproperty
  a_mag: assert property (p_mag) else $error("offset magnitude too big");
  property p_meas; temp_meas_done && therm_en |=> temp_value == $past(temp_meas_value); endproperty
  a_meas: assert property (p_meas) else $error("measurement not stored");
  // with the thermometer on only a measurement may move the value
  property p_live; $changed(temp_value) && $past(therm_en) |-> $past(temp_meas_done); endproperty
  a_live: assert property (p_live) else $error("temperature moved without measurement");
  property p_fast; temp_meas_req && therm_en && !temp_scan_interval_sel
    |-> ##FAST (temp_meas_req || !therm_en || temp_scan_interval_sel); endproperty
  a_fast: assert property (p_fast) else $error("fast scan period wrong");
  property p_slow; temp_meas_req && therm_en && temp_scan_interval_sel
    |-> ##[SLOW:SLOW] (temp_meas_req || !therm_en || !temp_scan_interval_sel); endproperty
  a_slow: assert property (p_slow) else $error("slow scan period wrong");
  property p_req; temp_meas_req |-> $past(therm_en); endproperty
  a_req: assert property (p_req) else $error("request with thermometer off");
endmodule // trt_regs_sva
bind trt_regs trt_regs_sva #(.SEC_CYCLES(SEC_CYCLES)) u_sva (.clk, .rst_n, .spi_cs_n, .temp_meas_value,
  .temp_meas_done, .temp_meas_req, .countdown_value, .clk_out_sel_hi, .clk_out_sel_lo, .therm_en,
  .temp_scan_interval_sel, .temp_value, .crystal_frequency_offset_mag);

// >>> test/trt_host.sv
`timescale 1ns/10ps
module trt_host (
  input wire clk,
  input wire miso,
  output logic sclk = 1'b0,
  output logic cs_n = 1'b1,
  output logic mosi = 1'b0
);
  // mode 0, slow half periods so the synchronisers always see each level
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      repeat (8) @(negedge clk);
      rx[i] = miso;
      sclk = 1'b1;
      repeat (8) @(negedge clk);
      sclk = 1'b0;
    end
  endtask
  task automatic start();
    cs_n = 1'b0;
    repeat (6) @(negedge clk);
  endtask
  // idle data line toggles so a stale level never looks like data
  task automatic stop();
    repeat (8) @(negedge clk);
    cs_n = 1'b1;
    mosi = ~mosi;
    repeat (8) @(negedge clk);
  endtask
endmodule // trt_host

// >>> test/trt_regs_test.sv
`timescale 1ns/10ps
`include "trt_defs.vh"
module trt_regs_test;
  logic clk = 0, rst_n = 0, done = 0;
  logic [7:0] mval = 0, rx0, rx1, v, w, got;
  logic [7:0] exp_q[$];
  wire sclk, cs_n, mosi, miso, miso_o, oe, req, t_en, s_h, s_l, scan, fast, r3, r2, r1, r0;
  wire [15:0] cnt;
  wire [7:0] temp, coef;
  wire [6:0] mag;
  wire [5:0] t0;
  int err_total = 0, n_checks = 0, cyc = 0;
  string what;
  event got_ev;
  logic [6:0] ra[10] = '{7'h18, 7'h19, 7'h20, 7'h28, 7'h29, 7'h30, 7'h31, 7'h32, 7'h33, 7'h21};
  logic [7:0] rv[10] = '{8'h01, 8'h00, 8'h3c, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};
  initial forever #2.5 clk = ~clk;
  trt_host host (.clk(clk), .miso(miso), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  trt_regs #(.SEC_CYCLES(20)) dut (.clk(clk), .rst_n(rst_n), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso_o(miso_o), .spi_miso_oe(oe), .temp_meas_value(mval), .temp_meas_done(done), .temp_meas_req(req),
    .countdown_value(cnt), .charge_res_largest_en(r3), .charge_res_large_en(r2), .charge_res_medium_en(r1),
    .charge_res_small_en(r0), .clk_out_sel_hi(s_h), .clk_out_sel_lo(s_l), .therm_en(t_en),
    .temp_scan_interval_sel(scan), .temp_value(temp), .crystal_frequency_offset_fast(fast), .crystal_frequency_offset_mag(mag),
    .xtal_coef(coef), .xtal_turnover(t0));
  // a released data line shows the inverse, so a read without the enable fails
  assign miso = oe ? miso_o : ~miso_o;
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
    exp_q.push_back(e);
    what = n;
    got = g;
    ->got_ev;
    @(negedge clk);
  endtask
  always @(got_ev) begin
    n_checks++;
    if (exp_q[0] !== got) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp_q[0], got);
    end
    void'(exp_q.pop_front());
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      conclude();
    end
  end
  task automatic xf(input logic [7:0] c, input logic [7:0] d0, input logic [7:0] d1, input int n);
    host.start();
    host.xfer(c, rx0);
    host.xfer(d0, rx0);
    if (n > 1)
      host.xfer(d1, rx1);
    host.stop();
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    xf({1'b0, a}, d, 8'h00, 1);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    xf({1'b1, a}, 8'h00, 8'h00, 1);
    check("read", e, rx0);
  endtask
  task automatic meas(input logic [7:0] m);
    mval = m;
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
  endtask
  initial begin
    void'($urandom(32'hea5e));
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 10; i++)
      rd(ra[i], rv[i]);
    v = 8'($urandom_range(255, 1));
    w = 8'($urandom);
    xf({1'b0, `TRT_ADDR_CNT_LO}, v, w, 2);
    check("cnt_lo", v, cnt[7:0]);
    check("cnt_hi", w, cnt[15:8]);
    wr(`TRT_ADDR_CNT_LO, 8'h00);
    xf({1'b1, `TRT_ADDR_CNT_LO}, 8'h00, 8'h00, 2);
    check("cnt_lo", v, rx0);
    check("cnt_hi", w, rx1);
    v = 8'($urandom);
    w = 8'($urandom);
    xf({1'b0, `TRT_ADDR_USER0}, v, w, 2);
    xf({1'b1, `TRT_ADDR_USER0}, 8'h00, 8'h00, 2);
    check("user0", v, rx0);
    check("user1", w, rx1);
    for (int i = 0; i < 4; i++) begin
      v = {4'($urandom), 2'(i), 2'b00};
      wr(`TRT_ADDR_CTRL, v);
      check("ctrl", v, {r3, r2, r1, r0, s_h, s_l, t_en, scan});
    end
    v = 8'($urandom);
    wr(`TRT_ADDR_TEMP, v);
    rd(`TRT_ADDR_TEMP, v);
    wr(`TRT_ADDR_CTRL, 8'h02);
    wr(`TRT_ADDR_TEMP, ~v);
    check("temp", v, temp);
    meas(8'hfa);
    check("temp", 8'hfa, temp);
    fork
      rd(`TRT_ADDR_TEMP, 8'hfa);
      begin
        repeat (40) @(negedge clk);
        meas(8'h00);
      end
    join
    rd(`TRT_ADDR_TEMP, 8'h00);
    repeat (100) @(negedge clk);
    wr(`TRT_ADDR_CTRL, 8'h03);
    repeat (800) @(negedge clk);
    wr(`TRT_ADDR_XOFS, 8'hff);
    rd(`TRT_ADDR_XOFS, 8'hf9);
    v = {1'b0, 7'($urandom_range(121))};
    wr(`TRT_ADDR_XOFS, v);
    check("xofs", v, {fast, mag});
    // the host puts the factory offset back after testing the field
    wr(`TRT_ADDR_XOFS, `TRT_XOFS_RST);
    rd(`TRT_ADDR_XOFS, `TRT_XOFS_RST);
    wr(`TRT_ADDR_XT0, 8'hff);
    rd(`TRT_ADDR_XT0, 8'h3f);
    check("t0", 8'h3f, {2'b00, t0});
    v = 8'($urandom);
    wr(`TRT_ADDR_XCOEF, v);
    check("coef", v, coef);
    conclude();
  end
endmodule // trt_regs_test
